// ===== rtl/rafc_regs.vh
`ifndef RAFC_REGS_VH
`define RAFC_REGS_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define RAFC_CTRL       8'h00
`define RAFC_RANGE      8'h04
`define RAFC_FILT       8'h08
`define RAFC_SRC        8'h0c
`define RAFC_ZDAC       8'h10
`define RAFC_ODAC       8'h14
`define RAFC_GDAC       8'h18
`define RAFC_VGA        8'h1c
`define RAFC_CONV       8'h20
`define RAFC_RDG        8'h24
`define RAFC_AVG        8'h28
`define RAFC_ZLVL       8'h2c
`define RAFC_OFS0       8'h40
`define RAFC_NOFS       10
// ----------------------------------------
// Field positions
// ----------------------------------------
`define RAFC_CTRL_ARNG  0
`define RAFC_CTRL_AFLT  1
`define RAFC_CTRL_MODE  2
`define RAFC_SRC_CHB    4
`define RAFC_SRC_REAR   5
`define RAFC_CONV_BUSY  16
`define RAFC_CONV_DONE  17
`define RAFC_CONV_SAT   18
`define RAFC_AVG_VALID  16
// ----------------------------------------
// Operating modes and sources
// ----------------------------------------
`define RAFC_MODE_MEAS  2'h0
`define RAFC_MODE_ZERO  2'h1
`define RAFC_MODE_CAL   2'h2
`define RAFC_MODE_TEST  2'h3
`define RAFC_SRC_LPF    3'h0
`define RAFC_SRC_SENS   3'h1
`define RAFC_SRC_GND    3'h2
`define RAFC_SRC_ZDAC   3'h3
`define RAFC_SRC_ODAC   3'h4
`define RAFC_SRC_GDAC   3'h5
// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define RAFC_RST_BYTE   8'h00
`define RAFC_MAX_RANGE  3'h4
`define RAFC_MAX_FILT   4'h9
`define RAFC_FAST_LAST  4'h2
`define RAFC_CLK_MHZ    8'h7d
`define RAFC_CNT_MHZ    8'h04
`endif

// ===== rtl/rafc_top.v
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "rafc_regs.vh"

// Summary of operation
// R1 - Attenuator follows manual or controller range
// R2 - Filters 0-2 fast, 3-9 slow path
// R3 - Input mux selects exactly one source
// R4 - DAC sources only in their own mode; here zero DAC only in test mode, offset DAC only in zero mode
// R5 - Controller issues one simultaneous start-ramp
// R6 - Start-ramp starts counting at 4 MHz
// R7 - Ramp-end stops and holds the count
// R8 - Same conversion for every source
// R9 - Average is mean of last N
// R10 - N is two to filter number
// R11 - Filter number from manual or automatic
// R12 - Zeroing stores ten offsets after zero DAC
// R13 - Zeroing done before any calibration
// R14 - Calibration picks variable gain setting
// R15 - Calibration rewrites ten offsets, offset DAC
// R16 - Calibration finds gain DAC for 1 V
// R17 - Calibration sets range and filters first
// R18 - Stored offsets define zero level
// R19 - Counter saturates without ramp-end
// R20 - Filter change restarts averaging history
module rafc_top #(
   parameter DW     = 16,
   parameter HDEPTH = 512,
   parameter HAW    = 9,
   parameter CW     = 16
) (
   input  wire          CLK_I,
   input  wire          NRST_I,
   input  wire [7:0]    AWADDR_I,
   input  wire          AWVALID_I,
   output wire          AWREADY_O,
   input  wire [31:0]   WDATA_I,
   input  wire [3:0]    WSTRB_I,
   input  wire          WVALID_I,
   output wire          WREADY_O,
   output reg  [1:0]    BRESP_O,
   output reg           BVALID_O,
   input  wire          BREADY_I,
   input  wire [7:0]    ARADDR_I,
   input  wire          ARVALID_I,
   output wire          ARREADY_O,
   output reg  [31:0]   RDATA_O,
   output reg  [1:0]    RRESP_O,
   output reg           RVALID_O,
   input  wire          RREADY_I,
   input  wire          RAMP_END_I,
   output reg           START_RAMP_O,
   output reg  [2:0]    RANGE_ATTN_O,
   output reg           LP_SLOW_O,
   output reg  [5:0]    ADC_SRC_O,
   output reg           SENS_CHB_O,
   output reg           SENS_REAR_O,
   output reg  [7:0]    ZERO_DAC_O,
   output reg  [7:0]    OFFSET_DAC_O,
   output reg  [7:0]    GAIN_DAC_O,
   output reg  [7:0]    VGAIN_O
);

   // ----------------------------------------
   // Register storage
   // ----------------------------------------
   reg  [7:0]    ctrl;
   reg  [7:0]    rng;
   reg  [7:0]    filt;
   reg  [7:0]    src;
   reg  [DW-1:0] ofs [0:`RAFC_NOFS-1];
   reg  [7:0]    aw_addr;
   reg           aw_held;
   reg  [31:0]   w_data;
   reg  [3:0]    w_strb;
   reg           w_held;
   reg           ramp_meta;
   reg           ramp_sync;
   reg           busy;
   reg           done;
   reg  [CW-1:0] count;
   reg  [7:0]    rate_acc;
   reg  [DW-1:0] hist [0:HDEPTH-1];
   reg  [HAW-1:0] wp;
   reg  [HAW:0]  fill;
   reg  [DW+HAW-1:0] sum;
   reg  [3:0]    fnum_q;
   reg  [DW-1:0] avg;
   reg           avg_valid;
   integer       i;

   wire [1:0]    mode   = ctrl[`RAFC_CTRL_MODE+1:`RAFC_CTRL_MODE];
   wire          do_wr  = aw_held && w_held && !BVALID_O;
   wire          start  = do_wr && (aw_addr == `RAFC_CONV) && w_strb[0] && w_data[0];
   wire          push   = do_wr && (aw_addr == `RAFC_RDG);
   wire          ofs_hit = (aw_addr >= `RAFC_OFS0) && (aw_addr < (`RAFC_OFS0 + 8'h28));
   wire [7:0]    ofs_woff = aw_addr - `RAFC_OFS0;
   wire [3:0]    ofs_wi  = ofs_woff[5:2];

   assign AWREADY_O = !aw_held && !BVALID_O;
   assign WREADY_O  = !w_held && !BVALID_O;
   assign ARREADY_O = !RVALID_O;

   // Byte-lane merge of a write into an existing word
   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0]  strb;
      integer      b;
      begin
         for (b = 0; b < 4; b = b + 1) begin
            merge[b*8 +: 8] = strb[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
         end
      end
   endfunction

   // ----------------------------------------
   // Effective range and filter number
   // ----------------------------------------
   reg  [2:0]    next_range;
   reg  [3:0]    next_fnum;
   always @* begin
      next_range = ctrl[`RAFC_CTRL_ARNG] ? rng[6:4] : rng[2:0]; // R1
      if (next_range > `RAFC_MAX_RANGE) begin
         next_range = `RAFC_MAX_RANGE;
      end
      next_fnum = ctrl[`RAFC_CTRL_AFLT] ? filt[7:4] : filt[3:0]; // R11
      if (next_fnum > `RAFC_MAX_FILT) begin
         next_fnum = `RAFC_MAX_FILT;
      end
   end

   // Offset table index: two entries per range, fast then slow
   wire          next_slow = (next_fnum > `RAFC_FAST_LAST); // R2
   wire [3:0]    zl_idx    = {next_range, 1'b0} + {3'h0, next_slow};

   // ----------------------------------------
   // Input multiplexer decode
   // ----------------------------------------
   // A DAC source requested outside its mode falls back to ground so
   // the comparator never sees a stray reference during measurement.
   reg  [2:0]    next_src;
   always @* begin
      next_src = src[2:0];
      case (src[2:0])
         `RAFC_SRC_ZDAC: if (mode != `RAFC_MODE_TEST) next_src = `RAFC_SRC_GND; // R4
         `RAFC_SRC_ODAC: if (mode != `RAFC_MODE_ZERO) next_src = `RAFC_SRC_GND; // R4
         `RAFC_SRC_GDAC: if (mode != `RAFC_MODE_CAL)  next_src = `RAFC_SRC_GND; // R4
         `RAFC_SRC_LPF, `RAFC_SRC_SENS, `RAFC_SRC_GND: next_src = src[2:0];
         default: next_src = `RAFC_SRC_GND;
      endcase
   end

   // ----------------------------------------
   // AXI4-Lite write path and registers
   // ----------------------------------------
   wire [31:0]   ofs_mrg = merge({{(32-DW){1'b0}}, ofs[ofs_wi]}, w_data, w_strb);
   always @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         aw_held  <= 1'b0;
         aw_addr  <= 8'h00;
         w_held   <= 1'b0;
         w_data   <= 32'h0000_0000;
         w_strb   <= 4'h0;
         BVALID_O <= 1'b0;
         BRESP_O  <= 2'h0;
         ctrl     <= `RAFC_RST_BYTE;
         rng      <= `RAFC_RST_BYTE;
         filt     <= `RAFC_RST_BYTE;
         src      <= `RAFC_RST_BYTE;
         ZERO_DAC_O   <= `RAFC_RST_BYTE;
         OFFSET_DAC_O <= `RAFC_RST_BYTE;
         GAIN_DAC_O   <= `RAFC_RST_BYTE;
         VGAIN_O      <= `RAFC_RST_BYTE;
         for (i = 0; i < `RAFC_NOFS; i = i + 1) begin
            ofs[i] <= {DW{1'b0}};
         end
      end else begin
         if (AWVALID_I && AWREADY_O) begin
            aw_held <= 1'b1;
            aw_addr <= AWADDR_I;
         end
         if (WVALID_I && WREADY_O) begin
            w_held <= 1'b1;
            w_data <= WDATA_I;
            w_strb <= WSTRB_I;
         end
         if (BVALID_O && BREADY_I) begin
            BVALID_O <= 1'b0;
         end
         if (do_wr) begin
            aw_held  <= 1'b0;
            w_held   <= 1'b0;
            BVALID_O <= 1'b1;
            BRESP_O  <= 2'h0;
            case (aw_addr)
               `RAFC_CTRL:  if (w_strb[0]) ctrl <= w_data[7:0];
               `RAFC_RANGE: if (w_strb[0]) rng <= w_data[7:0]; // R17
               `RAFC_FILT:  if (w_strb[0]) filt <= w_data[7:0]; // R17
               `RAFC_SRC:   if (w_strb[0]) src <= w_data[7:0];
               `RAFC_ZDAC:  if (w_strb[0]) ZERO_DAC_O <= w_data[7:0]; // R12
               `RAFC_ODAC:  if (w_strb[0]) OFFSET_DAC_O <= w_data[7:0]; // R15
               `RAFC_GDAC:  if (w_strb[0]) GAIN_DAC_O <= w_data[7:0]; // R16
               `RAFC_VGA:   if (w_strb[0]) VGAIN_O <= w_data[7:0]; // R14
               `RAFC_CONV, `RAFC_RDG: BRESP_O <= 2'h0;
               default: begin
                  if (ofs_hit) begin
                     ofs[ofs_wi] <= ofs_mrg[DW-1:0]; // R12 R15
                  end else begin
                     BRESP_O <= 2'h2;
                  end
               end
            endcase
         end
      end
   end

   // ----------------------------------------
   // AXI4-Lite read path
   // ----------------------------------------
   wire          rofs_hit = (ARADDR_I >= `RAFC_OFS0) && (ARADDR_I < (`RAFC_OFS0 + 8'h28));
   wire [7:0]    ofs_roff = ARADDR_I - `RAFC_OFS0;
   wire [3:0]    ofs_ri   = ofs_roff[5:2];
   always @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         RVALID_O <= 1'b0;
         RDATA_O  <= 32'h0000_0000;
         RRESP_O  <= 2'h0;
      end else begin
         if (RVALID_O && RREADY_I) begin
            RVALID_O <= 1'b0;
         end
         if (ARVALID_I && ARREADY_O) begin
            RVALID_O <= 1'b1;
            RRESP_O  <= 2'h0;
            RDATA_O  <= 32'h0000_0000;
            case (ARADDR_I)
               `RAFC_CTRL:  RDATA_O <= {24'h0, ctrl};
               `RAFC_RANGE: RDATA_O <= {24'h0, rng};
               `RAFC_FILT:  RDATA_O <= {24'h0, filt};
               `RAFC_SRC:   RDATA_O <= {24'h0, src};
               `RAFC_ZDAC:  RDATA_O <= {24'h0, ZERO_DAC_O};
               `RAFC_ODAC:  RDATA_O <= {24'h0, OFFSET_DAC_O};
               `RAFC_GDAC:  RDATA_O <= {24'h0, GAIN_DAC_O};
               `RAFC_VGA:   RDATA_O <= {24'h0, VGAIN_O};
               `RAFC_CONV:  RDATA_O <= {13'h0, &count, done, busy, {(16-CW){1'b0}}, count}; // R7 R19
               `RAFC_RDG:   RDATA_O <= 32'h0000_0000;
               `RAFC_AVG:   RDATA_O <= {15'h0, avg_valid, avg}; // R9
               `RAFC_ZLVL:  RDATA_O <= {{(32-DW){1'b0}}, ofs[zl_idx]}; // R18
               default: begin
                  if (rofs_hit) begin
                     RDATA_O <= {{(32-DW){1'b0}}, ofs[ofs_ri]};
                  end else begin
                     RRESP_O <= 2'h2;
                  end
               end
            endcase
         end
      end
   end

   // ----------------------------------------
   // Analog configuration outputs
   // ----------------------------------------
   always @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         RANGE_ATTN_O <= 3'h0;
         LP_SLOW_O    <= 1'b0;
         ADC_SRC_O    <= 6'h04;
         SENS_CHB_O   <= 1'b0;
         SENS_REAR_O  <= 1'b0;
      end else begin
         RANGE_ATTN_O <= next_range; // R1
         LP_SLOW_O    <= next_slow; // R2
         ADC_SRC_O    <= 6'h01 << next_src; // R3
         SENS_CHB_O   <= src[`RAFC_SRC_CHB];
         SENS_REAR_O  <= src[`RAFC_SRC_REAR];
      end
   end

   // ----------------------------------------
   // Ramp conversion timer
   // ----------------------------------------
   // 4 MHz is not an integer division of the clock, so a fractional
   // accumulator spaces the count enables; jitter is one clock period.
   wire [7:0]    acc_sum = rate_acc + `RAFC_CNT_MHZ;
   wire          tick    = (acc_sum >= `RAFC_CLK_MHZ);

   // Source selection never enters here, so every input converts alike
   always @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         ramp_meta    <= 1'b0;
         ramp_sync    <= 1'b0;
         START_RAMP_O <= 1'b0;
         busy         <= 1'b0;
         done         <= 1'b0;
         count        <= {CW{1'b0}};
         rate_acc     <= 8'h00;
      end else begin
         ramp_meta    <= RAMP_END_I;
         ramp_sync    <= ramp_meta;
         START_RAMP_O <= 1'b0;
         if (start) begin
            START_RAMP_O <= 1'b1; // R5 R6
            busy         <= 1'b1; // R6 R8
            done         <= 1'b0;
            count        <= {CW{1'b0}};
            rate_acc     <= 8'h00;
         end else if (busy) begin
            if (ramp_sync) begin
               busy <= 1'b0; // R7
               done <= 1'b1; // R7
            end else begin
               rate_acc <= tick ? acc_sum - `RAFC_CLK_MHZ : acc_sum;
               if (tick && !(&count)) begin
                  count <= count + 1'b1; // R6 R19
               end
            end
         end
      end
   end

   // ----------------------------------------
   // Averaging filter
   // ----------------------------------------
   wire [HAW:0]  len     = {{HAW{1'b0}}, 1'b1} << next_fnum; // R10
   wire [HAW-1:0] old_ix = wp - len[HAW-1:0];
   wire [DW-1:0] rdg     = w_data[DW-1:0];
   wire [DW+HAW-1:0] mean_w = sum >> next_fnum;

   always @(posedge CLK_I) begin
      if (push) begin
         hist[wp] <= rdg;
      end
   end

   always @(posedge CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
         wp        <= {HAW{1'b0}};
         fill      <= {(HAW+1){1'b0}};
         sum       <= {(DW+HAW){1'b0}};
         fnum_q    <= 4'h0;
         avg       <= {DW{1'b0}};
         avg_valid <= 1'b0;
      end else begin
         fnum_q <= next_fnum;
         if (fnum_q != next_fnum) begin
            wp        <= {HAW{1'b0}}; // R20
            fill      <= {(HAW+1){1'b0}}; // R20
            sum       <= {(DW+HAW){1'b0}}; // R20
            avg_valid <= 1'b0; // R20
         end else begin
            if (push) begin
               wp <= wp + 1'b1;
               if (fill == len) begin
                  sum <= sum + rdg - hist[old_ix]; // R9
               end else begin
                  sum  <= sum + rdg;
                  fill <= fill + 1'b1;
               end
            end
            avg_valid <= (fill == len);
            avg       <= mean_w[DW-1:0]; // R9 R10
         end
      end
   end

endmodule

// ===== verif/rafc_checker.sv
`timescale 1ns/10ps
module rafc_checker (
   input wire        CLK_I,
   input wire        NRST_I,
   input wire        AWVALID_I,
   input wire        AWREADY_O,
   input wire        WVALID_I,
   input wire        WREADY_O,
   input wire [1:0]  BRESP_O,
   input wire        BVALID_O,
   input wire        BREADY_I,
   input wire        ARVALID_I,
   input wire        ARREADY_O,
   input wire [31:0] RDATA_O,
   input wire [1:0]  RRESP_O,
   input wire        RVALID_O,
   input wire        RREADY_I,
   input wire        START_RAMP_O,
   input wire [2:0]  RANGE_ATTN_O,
   input wire [5:0]  ADC_SRC_O
);
   // ----------------------------------------
   // Bus and converter properties
   // ----------------------------------------
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!NRST_I);
   wr_answer_a: assert property (AWVALID_I && AWREADY_O && WVALID_I && WREADY_O |-> ##2 BVALID_O)
      else $error("write answer late");
   b_hold_a: assert property (BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O))
      else $error("write answer dropped");
   b_block_a: assert property (BVALID_O |-> !AWREADY_O && !WREADY_O)
      else $error("write taken while answer pending");
   rd_answer_a: assert property (ARVALID_I && ARREADY_O |=> RVALID_O)
      else $error("read answer late");
   r_hold_a: assert property (RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O))
      else $error("read answer dropped");
   r_block_a: assert property (RVALID_O |-> !ARREADY_O)
      else $error("read taken while answer pending");
   err_zero_a: assert property (RVALID_O && RRESP_O == 2'h2 |-> RDATA_O == 32'h0)
      else $error("error read carries data");
   src_onehot_a: assert property ($onehot(ADC_SRC_O))
      else $error("converter input not one source");
   range_max_a: assert property (RANGE_ATTN_O <= 3'h4)
      else $error("range beyond top range");
   // A start is only legal on a write commit and lasts one cycle
   start_pulse_a: assert property (START_RAMP_O |-> $rose(BVALID_O) ##1 !START_RAMP_O)
      else $error("start pulse malformed");
   cover property (START_RAMP_O);
   cover property (RVALID_O && RRESP_O == 2'h2);
   cover property (BVALID_O && !BREADY_I ##1 BVALID_O && BREADY_I);
endmodule
bind rafc_top rafc_checker rafc_checker_inst (.CLK_I, .NRST_I, .AWVALID_I, .AWREADY_O, .WVALID_I,
   .WREADY_O, .BRESP_O, .BVALID_O, .BREADY_I, .ARVALID_I, .ARREADY_O, .RDATA_O, .RRESP_O,
   .RVALID_O, .RREADY_I, .START_RAMP_O, .RANGE_ATTN_O, .ADC_SRC_O);

// ===== verif/rafc_ramp_model.sv
`timescale 1ns/10ps
module rafc_ramp_model (
   input  wire  clk_i,
   input  wire  start_i,
   input  int   delay_i,
   output wire  ramp_end_o
);
   // ----------------------------------------
   // Ramp and comparator
   // ----------------------------------------
   int t = 0;
   // Ramp meets the input delay_i cycles after start, then discharges
   // so the comparator falls again; 0 means the ramp never meets it
   always @(posedge clk_i) begin
      if (start_i)
         t <= (delay_i > 0) ? delay_i + 8 : 0;
      else if (t > 0)
         t <= t - 1;
   end
   assign ramp_end_o = (t > 0) && (t <= 8);
endmodule

// ===== verif/rafc_top_bench.sv
`timescale 1ns/10ps
`include "rafc_regs.vh"
module rafc_top_bench;
   // ----------------------------------------
   // Stimulus and design
   // ----------------------------------------
   logic        CLK_I = 0, NRST_I = 0, AWVALID_I = 0, WVALID_I = 0;
   logic        BREADY_I = 0, ARVALID_I = 0, RREADY_I = 0;
   logic [7:0]  AWADDR_I = 0, ARADDR_I = 0;
   logic [31:0] WDATA_I = 0;
   logic [3:0]  WSTRB_I = 4'hf;
   wire         AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O, RAMP_END_I;
   wire         START_RAMP_O, LP_SLOW_O, SENS_CHB_O, SENS_REAR_O;
   wire  [1:0]  BRESP_O, RRESP_O;
   wire  [31:0] RDATA_O;
   wire  [2:0]  RANGE_ATTN_O;
   wire  [5:0]  ADC_SRC_O;
   wire  [7:0]  ZERO_DAC_O, OFFSET_DAC_O, GAIN_DAC_O, VGAIN_O;
   int          n_fail = 0, tests_run = 0, cyc = 0, delay = 1000;
   logic [31:0] q;
   logic [15:0] c1, c2;
   rafc_top rafc_top_inst (.CLK_I, .NRST_I, .AWADDR_I, .AWVALID_I, .AWREADY_O, .WDATA_I, .WSTRB_I,
      .WVALID_I, .WREADY_O, .BRESP_O, .BVALID_O, .BREADY_I, .ARADDR_I, .ARVALID_I, .ARREADY_O,
      .RDATA_O, .RRESP_O, .RVALID_O, .RREADY_I, .RAMP_END_I, .START_RAMP_O, .RANGE_ATTN_O,
      .LP_SLOW_O, .ADC_SRC_O, .SENS_CHB_O, .SENS_REAR_O, .ZERO_DAC_O, .OFFSET_DAC_O,
      .GAIN_DAC_O, .VGAIN_O);
   rafc_ramp_model rafc_ramp_model_inst (.clk_i(CLK_I), .start_i(START_RAMP_O), .delay_i(delay),
      .ramp_end_o(RAMP_END_I));
   initial forever #4 CLK_I = ~CLK_I;
   // Whole run needs well under half this
   always @(posedge CLK_I) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail = n_fail + 1;
         summarize();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run = tests_run + 1;
      if (seen !== exp) begin
         n_fail = n_fail + 1;
         $display("mismatch at %0t: seen %h, expected %h", $time, seen, exp);
      end
   endtask
   // ----------------------------------------
   // Bus master
   // ----------------------------------------
   // Ready is raised only after the answer shows, so the hold logic is
   // exercised; one idle edge keeps back-to-back calls race free
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      AWADDR_I <= a;
      WDATA_I <= d;
      AWVALID_I <= 1'b1;
      WVALID_I <= 1'b1;
      do begin
         @(posedge CLK_I);
         if (AWVALID_I && AWREADY_O) AWVALID_I <= 1'b0;
         if (WVALID_I && WREADY_O) WVALID_I <= 1'b0;
      end while (!BVALID_O);
      check(BRESP_O, er);
      BREADY_I <= 1'b1;
      @(posedge CLK_I);
      BREADY_I <= 1'b0;
      @(posedge CLK_I);
   endtask
   task automatic rd(input logic [7:0] a, input logic [1:0] er);
      ARADDR_I <= a;
      ARVALID_I <= 1'b1;
      do begin
         @(posedge CLK_I);
         if (ARVALID_I && ARREADY_O) ARVALID_I <= 1'b0;
      end while (!RVALID_O);
      q = RDATA_O;
      check(RRESP_O, er);
      RREADY_I <= 1'b1;
      @(posedge CLK_I);
      RREADY_I <= 1'b0;
      @(posedge CLK_I);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      rd(a, 2'h0);
      check(q, exp);
   endtask
   task automatic summarize();
      $display("checks %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_range();
      wr(`RAFC_RANGE, 32'h13, 2'h0);
      wr(`RAFC_CTRL, 32'h0, 2'h0);
      check(RANGE_ATTN_O, 3'h3);
      wr(`RAFC_CTRL, 32'h1, 2'h0);
      check(RANGE_ATTN_O, 3'h1);
      wr(`RAFC_RANGE, 32'h63, 2'h0);
      check(RANGE_ATTN_O, 3'h4);
      $display("range test done");
   endtask
   task automatic t_filt();
      wr(`RAFC_CTRL, 32'h0, 2'h0);
      for (int n = 0; n < 10; n++) begin
         wr(`RAFC_FILT, n, 2'h0);
         check(LP_SLOW_O, n > 2);
      end
      wr(`RAFC_FILT, 32'h51, 2'h0);
      check(LP_SLOW_O, 1'b0);
      wr(`RAFC_CTRL, 32'h2, 2'h0);
      check(LP_SLOW_O, 1'b1);
      $display("filter test done");
   endtask
   task automatic t_src();
      logic [5:0] e;
      for (int m = 0; m < 4; m++) begin
         wr(`RAFC_CTRL, m << 2, 2'h0);
         for (int s = 0; s < 7; s++) begin
            wr(`RAFC_SRC, s, 2'h0);
            e = (s < 3 || (s == 3 && m == 3) || (s == 4 && m == 1) || (s == 5 && m == 2)) ? 6'h01 << s : 6'h04;
            check(ADC_SRC_O, e);
         end
      end
      wr(`RAFC_SRC, 32'h31, 2'h0);
      check({SENS_REAR_O, SENS_CHB_O, ADC_SRC_O}, {2'h3, 6'h02});
      $display("source test done");
   endtask
   task automatic t_dac();
      wr(`RAFC_CTRL, 32'h4, 2'h0);
      wr(`RAFC_CTRL, 32'h8, 2'h0);
      wr(`RAFC_ZDAC, 32'ha5, 2'h0);
      wr(`RAFC_ODAC, 32'h5a, 2'h0);
      wr(`RAFC_GDAC, 32'h3c, 2'h0);
      wr(`RAFC_VGA, 32'hc3, 2'h0);
      check({ZERO_DAC_O, OFFSET_DAC_O, GAIN_DAC_O, VGAIN_O}, 32'ha55a3cc3);
      rdc(`RAFC_GDAC, 32'h3c);
      $display("dac test done");
   endtask
   task automatic conv(input logic [31:0] s, output logic [15:0] c);
      wr(`RAFC_SRC, s, 2'h0);
      wr(`RAFC_CONV, 32'h1, 2'h0);
      rd(`RAFC_CONV, 2'h0);
      check(q[17:16], 2'h1);
      do rd(`RAFC_CONV, 2'h0); while (q[17] !== 1'b1);
      check(q[16], 1'b0);
      c = q[15:0];
   endtask
   task automatic t_conv();
      wr(`RAFC_CTRL, 32'h0, 2'h0);
      conv(32'h0, c1);
      // About 1003 clocks of 8 ns at 4 MHz gives 32 counts
      check(c1 >= 31 && c1 <= 33, 1'b1);
      conv(32'h2, c2);
      check(c2 + 1 >= c1 && c2 <= c1 + 1, 1'b1);
      repeat (100) @(posedge CLK_I);
      rdc(`RAFC_CONV, {13'h0, 3'h2, c2});
      // A ramp that never meets the input keeps the timer running
      delay = 0;
      wr(`RAFC_CONV, 32'h1, 2'h0);
      repeat (300) @(posedge CLK_I);
      rd(`RAFC_CONV, 2'h0);
      check(q[18:16], 3'h1);
      check(q[15:0] >= 8 && q[15:0] <= 12, 1'b1);
      $display("conversion test done");
   endtask
   task automatic t_avg();
      wr(`RAFC_FILT, 32'h2, 2'h0);
      for (int i = 1; i < 4; i++) wr(`RAFC_RDG, i * 10, 2'h0);
      rd(`RAFC_AVG, 2'h0);
      check(q[16], 1'b0);
      wr(`RAFC_RDG, 32'd40, 2'h0);
      rdc(`RAFC_AVG, 32'h10019);
      wr(`RAFC_RDG, 32'd50, 2'h0);
      rdc(`RAFC_AVG, 32'h10023);
      wr(`RAFC_FILT, 32'h1, 2'h0);
      rd(`RAFC_AVG, 2'h0);
      check(q[16], 1'b0);
      wr(`RAFC_RDG, 32'd8, 2'h0);
      wr(`RAFC_RDG, 32'd4, 2'h0);
      rdc(`RAFC_AVG, 32'h10006);
      wr(`RAFC_FILT, 32'h9, 2'h0);
      for (int i = 0; i < 511; i++) wr(`RAFC_RDG, 32'd3, 2'h0);
      rd(`RAFC_AVG, 2'h0);
      check(q[16], 1'b0);
      wr(`RAFC_RDG, 32'd3, 2'h0);
      rdc(`RAFC_AVG, 32'h10003);
      $display("average test done");
   endtask
   task automatic t_ofs();
      wr(`RAFC_RANGE, 32'h2, 2'h0);
      wr(`RAFC_OFS0 + 8'h14, 32'h1234, 2'h0);
      wr(`RAFC_OFS0 + 8'h10, 32'h0abc, 2'h0);
      rdc(`RAFC_ZLVL, 32'h1234);
      wr(`RAFC_FILT, 32'h1, 2'h0);
      rdc(`RAFC_ZLVL, 32'h0abc);
      wr(8'h3c, 32'h1, 2'h2);
      rd(8'h3c, 2'h2);
      check(q, 32'h0);
      rdc(`RAFC_RDG, 32'h0);
      WSTRB_I <= 4'h1;
      wr(`RAFC_OFS0 + 8'h14, 32'h5678, 2'h0);
      WSTRB_I <= 4'hf;
      rdc(`RAFC_OFS0 + 8'h14, 32'h1278);
      $display("offset test done");
   endtask
   initial begin
      repeat (8) @(posedge CLK_I);
      check(ADC_SRC_O, 6'h04);
      NRST_I <= 1'b1;
      @(posedge CLK_I);
      t_range();
      t_filt();
      t_src();
      t_dac();
      t_conv();
      t_avg();
      t_ofs();
      summarize();
   end
endmodule
